// [verilog/ucdb_pkg.sv]
// Functional notes
// R1: 9-bit filter: flag only if ninth bit set
// R2: Bit 4 enables reception
// R3: Bit 3 sent as ninth bit in 9-bit mode
// R4: Bit 2 gets stop or ninth bit
// R5: Transmit-done set at stop bit start
// R6: Transmit-done requests interrupt, software clears
// R7: Receive-done set at stop bit sampling
// R8: Receive-done requests interrupt, software clears
// R9: Data write loads shifter, starts transmission; the code queues the write and loads the shifter once the transmitter is idle
// R10: Data read returns receive latch
// R11: Software sets timer reload for baud
// R12: 9-bit frame is eleven bits
// R13: Load only if receive-done clear, filter met
// R14: Bit 7 selects 8 or 9-bit frames
// R15: 8-bit filter: flag only if stop set
// R16: Interrupt is enabled OR of flags
package ucdb_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] CTRL_ADDR  = 8'h98;
	localparam logic [7:0] DATA_ADDR  = 8'h99;
	localparam logic [7:0] CTRL_RESET = 8'h40;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int         BIT_MODE   = 7;
	localparam int         BIT_ONE    = 6;
	localparam int         BIT_MCE    = 5;
	localparam int         BIT_REN    = 4;
	localparam int         BIT_TB8    = 3;
	localparam int         BIT_RB8    = 2;
	localparam int         BIT_TI     = 1;
	localparam int         BIT_RI     = 0;

	// ****************************************
	// Framing and timing
	// ****************************************
	localparam int         DATA_BITS    = 8;
	localparam int         OVF_PER_BIT  = 2;
	localparam int         FIFO_DEPTH   = 16;
	localparam logic [7:0] RELOAD_115K2 = 8'h96;
	localparam int         DIVIDE_115K2 = 212;
endpackage

// [verilog/ucdb_tick_div.sv]
`timescale 1ns/1ps
module ucdb_tick_div #(
	parameter int DIV = 2
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic sync_clr,
	input  wire logic tick_in,
	output logic      tick_out
);
	// ****************************************
	// Divide timer overflows to bit enables
	// ****************************************
	localparam int CW = $clog2(DIV+1);
	logic [CW-1:0] cnt_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q    <= '0;
			tick_out <= 1'b0;
		end else if (sync_clr) begin
			cnt_q    <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (tick_in) begin
				if (cnt_q == CW'(DIV - 1)) begin
					cnt_q    <= '0;
					tick_out <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end
endmodule

// [verilog/ucdb_fifo.sv]
`timescale 1ns/1ps
module ucdb_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	// ****************************************
	// Storage and pointers
	// ****************************************
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;
	assign out_data = mem[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	// Flags kept in flops so ready is glitch free
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q      <= '0;
			rd_q      <= '0;
			cnt_q     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q     <= cnt_q + 1'b1;
				in_ready  <= (cnt_q != (AW+1)'(DEPTH - 1));
				out_valid <= 1'b1;
			end else if (pop && !push) begin
				cnt_q     <= cnt_q - 1'b1;
				in_ready  <= 1'b1;
				out_valid <= (cnt_q != (AW+1)'(1));
			end
		end
	end
endmodule

// [verilog/ucdb_uart.sv]
`timescale 1ns/1ps
module ucdb_uart #(
	parameter int FIFO_WIDTH = 9,
	parameter int FIFO_DEPTH = ucdb_pkg::FIFO_DEPTH
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	output logic            sfr_wr_ready,
	input  wire logic       timer_ovf,
	input  wire logic       port_irq_enable,
	input  wire logic       rxd,
	output logic            txd,
	output logic            port_irq
);
	// ****************************************
	// Types and declarations
	// ****************************************
	typedef enum logic [4:0] {
		TX_IDLE  = 5'h01,
		TX_START = 5'h02,
		TX_DATA  = 5'h04,
		TX_NINTH = 5'h08,
		TX_STOP  = 5'h10
	} ucdb_tx_e;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_NINTH = 5'h08,
		RX_STOP  = 5'h10
	} ucdb_rx_e;

	ucdb_tx_e   tx_st_q;
	ucdb_rx_e   rx_st_q;
	logic       mode9_q;
	logic       mce_q;
	logic       ren_q;
	logic       tb8_q;
	logic       rb8_q;
	logic       ti_q;
	logic       ri_q;
	logic [7:0] rx_latch_q;
	logic [7:0] tx_shift_q;
	logic       tx_bit9_q;
	logic [2:0] tx_cnt_q;
	logic [7:0] rx_shift_q;
	logic [2:0] rx_cnt_q;
	logic       rx_half_q;
	logic       rxd_prev_q;
	logic       rx_ninth_q;
	logic       tx_tick;
	logic       tx_go;
	logic       fifo_valid;
	logic [8:0] fifo_data;
	logic       wr_ctrl;
	logic       wr_data;
	logic       ti_set;
	logic       ri_set;
	logic       rx_mid;
	logic       rx_accept;
	logic       rx_check_bit;

	assign wr_ctrl = sfr_wr && (sfr_addr == ucdb_pkg::CTRL_ADDR);
	assign wr_data = sfr_wr && (sfr_addr == ucdb_pkg::DATA_ADDR);

	// ****************************************
	// Transmit buffer
	// ****************************************
	// Queue decouples software writes from line rate; a full queue drops
	// the write, so software must watch sfr_wr_ready.
	ucdb_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (wr_data),
		.in_ready  (sfr_wr_ready),
		// R3: capture ninth bit
		.in_data   ({tb8_q, sfr_wdata}),
		.out_valid (fifo_valid),
		.out_ready (tx_go),
		.out_data  (fifo_data)
	);

	// R9: start at once if idle
	assign tx_go = fifo_valid && (tx_st_q == TX_IDLE);

	ucdb_tick_div #(
		.DIV (ucdb_pkg::OVF_PER_BIT)
	) u_tick (
		.clk      (clk),
		.rst      (rst),
		.sync_clr (tx_go),
		.tick_in  (timer_ovf),
		.tick_out (tx_tick)
	);

	// ****************************************
	// Control register
	// ****************************************
	// R14: frame length select
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode9_q <= ucdb_pkg::CTRL_RESET[ucdb_pkg::BIT_MODE];
			mce_q   <= ucdb_pkg::CTRL_RESET[ucdb_pkg::BIT_MCE];
			ren_q   <= ucdb_pkg::CTRL_RESET[ucdb_pkg::BIT_REN];
			tb8_q   <= ucdb_pkg::CTRL_RESET[ucdb_pkg::BIT_TB8];
		end else if (wr_ctrl) begin
			mode9_q <= sfr_wdata[ucdb_pkg::BIT_MODE];
			mce_q   <= sfr_wdata[ucdb_pkg::BIT_MCE];
			ren_q   <= sfr_wdata[ucdb_pkg::BIT_REN];
			tb8_q   <= sfr_wdata[ucdb_pkg::BIT_TB8];
		end
	end

	// ****************************************
	// Done flags
	// ****************************************
	// R5: set entering stop bit
	assign ti_set = tx_tick && (tx_st_q == TX_DATA) && (tx_cnt_q == 3'h7) && !mode9_q
		|| tx_tick && (tx_st_q == TX_NINTH);

	// R6: hardware only sets
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ti_q <= ucdb_pkg::CTRL_RESET[ucdb_pkg::BIT_TI];
		end else if (ti_set) begin
			ti_q <= 1'b1;
		end else if (wr_ctrl) begin
			ti_q <= sfr_wdata[ucdb_pkg::BIT_TI];
		end
	end

	// R8: hardware only sets, set wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ri_q <= ucdb_pkg::CTRL_RESET[ucdb_pkg::BIT_RI];
		end else if (ri_set) begin
			ri_q <= 1'b1;
		end else if (wr_ctrl) begin
			ri_q <= sfr_wdata[ucdb_pkg::BIT_RI];
		end
	end

	// R16: gated OR of flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_irq <= 1'b0;
		end else begin
			port_irq <= port_irq_enable && (ti_q || ti_set || ri_q || ri_set);
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	// R12: start, eight data, ninth, stop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_st_q    <= TX_IDLE;
			tx_shift_q <= 8'h00;
			tx_bit9_q  <= 1'b0;
			tx_cnt_q   <= 3'h0;
			txd        <= 1'b1;
		end else begin
			case (tx_st_q)
				TX_IDLE: begin
					txd <= 1'b1;
					if (tx_go) begin
						tx_shift_q <= fifo_data[7:0];
						tx_bit9_q  <= fifo_data[8];
						tx_cnt_q   <= 3'h0;
						txd        <= 1'b0;
						tx_st_q    <= TX_START;
					end
				end
				TX_START: begin
					if (tx_tick) begin
						txd     <= tx_shift_q[0];
						tx_st_q <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (tx_tick) begin
						tx_cnt_q <= tx_cnt_q + 1'b1;
						if (tx_cnt_q == 3'h7) begin
							// R3: ninth bit only in 9-bit mode
							txd     <= mode9_q ? tx_bit9_q : 1'b1;
							tx_st_q <= mode9_q ? TX_NINTH : TX_STOP;
						end else begin
							txd        <= tx_shift_q[1];
							tx_shift_q <= {1'b0, tx_shift_q[7:1]};
						end
					end
				end
				TX_NINTH: begin
					if (tx_tick) begin
						txd     <= 1'b1;
						tx_st_q <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (tx_tick) begin
						tx_st_q <= TX_IDLE;
					end
				end
				default: begin
					tx_st_q <= TX_IDLE;
					txd     <= 1'b1;
				end
			endcase
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	// Mid-bit sample every second overflow after the start edge
	assign rx_mid = timer_ovf && !rx_half_q;

	// R1: ninth bit in 9-bit mode; R15: stop bit in 8-bit mode
	assign rx_check_bit = mode9_q ? rx_ninth_q : rxd;

	// R13: load only if flag clear and filter met
	assign rx_accept = (rx_st_q == RX_STOP) && rx_mid && !ri_q && (!mce_q || rx_check_bit);

	// R7: set at stop sampling
	assign ri_set = rx_accept;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxd_prev_q <= 1'b1;
		end else begin
			rxd_prev_q <= rxd;
		end
	end

	// R2: receive enable gates the state machine
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_st_q    <= RX_IDLE;
			rx_half_q  <= 1'b0;
			rx_cnt_q   <= 3'h0;
			rx_shift_q <= 8'h00;
			rx_ninth_q <= 1'b0;
		end else if (!ren_q) begin
			rx_st_q <= RX_IDLE;
		end else begin
			if (timer_ovf && rx_st_q != RX_IDLE) begin
				rx_half_q <= !rx_half_q;
			end
			case (rx_st_q)
				RX_IDLE: begin
					if (rxd_prev_q && !rxd) begin
						rx_half_q <= 1'b1;
						rx_cnt_q  <= 3'h0;
						rx_st_q   <= RX_START;
					end
				end
				RX_START: begin
					// False start rejected on a high mid-bit
					if (rx_mid) begin
						rx_st_q <= rxd ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_mid) begin
						rx_shift_q <= {rxd, rx_shift_q[7:1]};
						rx_cnt_q   <= rx_cnt_q + 1'b1;
						if (rx_cnt_q == 3'h7) begin
							rx_st_q <= mode9_q ? RX_NINTH : RX_STOP;
						end
					end
				end
				RX_NINTH: begin
					if (rx_mid) begin
						rx_ninth_q <= rxd;
						rx_st_q    <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_mid) begin
						rx_st_q <= RX_IDLE;
					end
				end
				default: begin
					rx_st_q <= RX_IDLE;
				end
			endcase
		end
	end

	// R4: stop bit or ninth bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rb8_q      <= ucdb_pkg::CTRL_RESET[ucdb_pkg::BIT_RB8];
			rx_latch_q <= ucdb_pkg::DATA_RESET;
		end else if (rx_accept) begin
			rb8_q      <= rx_check_bit;
			rx_latch_q <= rx_shift_q;
		end else if (wr_ctrl) begin
			rb8_q <= sfr_wdata[ucdb_pkg::BIT_RB8];
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// R10: data read returns receive latch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			case (sfr_addr)
				ucdb_pkg::CTRL_ADDR: sfr_rdata <= {mode9_q, 1'b1, mce_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
				ucdb_pkg::DATA_ADDR: sfr_rdata <= rx_latch_q;
				default:             sfr_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// [verif/ucdb_uart_assertions.sv]
`timescale 1ns/1ps
module ucdb_uart_assertions (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sfr_wr_ready,
	input wire logic       timer_ovf,
	input wire logic       port_irq_enable,
	input wire logic       txd,
	input wire logic       port_irq
);
	// ****
	// Port checks
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic dw;
	assign dw = sfr_wr && sfr_addr == 8'h99;

	a_irq_gated: assert property (!port_irq_enable |=> !port_irq)
		else $error("irq while disabled");
	a_irq_cause: assert property ($rose(port_irq) |-> $past(port_irq_enable))
		else $error("irq without enable");
	a_irq_sticky: assert property (port_irq && port_irq_enable && !$past(sfr_wr) |=> port_irq)
		else $error("flag dropped alone");
	a_rd_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved");
	a_unmapped_rd: assert property (sfr_rd && sfr_addr != 8'h98 && sfr_addr != 8'h99 |=> sfr_rdata == 8'h00)
		else $error("unmapped read");
	a_ctl_fixed: assert property (sfr_rd && sfr_addr == 8'h98 |=> sfr_rdata[6])
		else $error("fixed bit low");
	a_tx_on_ovf: assert property ($rose(txd) |-> $past(timer_ovf) || $past(timer_ovf, 2))
		else $error("bit edge off tick");
	// Ready may lag a taken write by one cycle
	a_ready_holds: assert property (sfr_wr_ready && !dw && !$past(dw) |=> sfr_wr_ready)
		else $error("ready fell alone");
	c_tx: cover property ($fell(txd));
	c_irq: cover property ($rose(port_irq));
	c_full: cover property ($fell(sfr_wr_ready));
endmodule

bind ucdb_uart ucdb_uart_assertions u_chk (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_wr_ready(sfr_wr_ready), .timer_ovf(timer_ovf),
	.port_irq_enable(port_irq_enable), .txd(txd), .port_irq(port_irq));

// [verif/ucdb_remote.sv]
`timescale 1ns/1ps
module ucdb_remote (
	input wire logic clk,
	input wire logic timer_ovf,
	input wire logic txd,
	output logic     rxd
);
	// ****
	// Remote serial end
	// ****
	logic [8:0] got[$];
	logic [8:0] f;
	initial rxd = 1'b1;
	// data LSB first, then ninth or stop
	always begin
		@(negedge txd);
		@(posedge clk iff timer_ovf);
		for (int i = 0; i < 9; i++) begin
			repeat (2) @(posedge clk iff timer_ovf);
			f[i] = txd;
		end
		got.push_back(f);
	end
	// start, eight data, ninth or stop, idle
	task send(input logic [7:0] d, input logic x);
		logic [10:0] fr;
		fr = {1'b1, x, d, 1'b0};
		@(posedge clk iff timer_ovf);
		for (int i = 0; i < 11; i++) begin
			rxd <= fr[i];
			repeat (2) @(posedge clk iff timer_ovf);
		end
	endtask
endmodule

// [verif/uart_control_and_data_buffer_tb_top.sv]
`timescale 1ns/1ps
module uart_control_and_data_buffer_tb_top;
	logic       clk;
	logic       rst;
	logic [7:0] sfr_addr;
	logic       sfr_wr;
	logic [7:0] sfr_wdata;
	logic       sfr_rd;
	logic [7:0] sfr_rdata;
	logic       sfr_wr_ready;
	logic       timer_ovf = 1'b0;
	logic       port_irq_enable;
	logic       rxd;
	logic       txd;
	logic       port_irq;
	int         num_errors;
	int         samples_checked;
	int         ticks = 0;
	logic       acc;
	logic [7:0] c;
	logic [7:0] d;
	logic [7:0] e;
	logic [8:0] q[$];

	ucdb_uart u_dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_wr_ready(sfr_wr_ready), .timer_ovf(timer_ovf),
		.port_irq_enable(port_irq_enable), .rxd(rxd), .txd(txd), .port_irq(port_irq));
	ucdb_remote u_far (.clk(clk), .timer_ovf(timer_ovf), .txd(txd), .rxd(rxd));

	// ****
	// Clock, tick, tasks
	// ****
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// tick every fourth cycle stands in for the baud timer
	always @(posedge clk) begin
		ticks <= ticks + 1;
		timer_ovf <= ticks[1:0] == 2'h3;
		if (ticks > 30000) begin
			num_errors++;
			stop_test();
		end
	end
	task stop_test();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [8:0] a, input logic [8:0] b);
		samples_checked++;
		if (a !== b) begin
			num_errors++;
			$display("unexpected %0t got %h want %h", $time, a, b);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_wr <= 1'b1;
		@(posedge clk);
		acc = sfr_wr_ready;
		sfr_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1;
		chk({1'b0, sfr_rdata}, {1'b0, x});
	endtask
	function logic [8:0] fexp(input logic m, input logic b, input logic [7:0] v);
		return {m ? b : 1'b1, v};
	endfunction

	initial begin
		rst = 1'b1;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_wdata = 8'h00;
		sfr_rd = 1'b0;
		port_irq_enable = 1'b1;
		void'($urandom(46));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(8'h98, 8'h40);
		rd(8'h9a, 8'h00);
		for (int m = 0; m < 2; m++) begin
			c = {m[0], 3'h1, 1'($urandom), 3'h0};
			d = 8'($urandom);
			wr(8'h98, c);
			wr(8'h99, d);
			while (u_far.got.size() == 0) @(posedge clk);
			repeat (12) @(posedge clk);
			chk(u_far.got.pop_front(), fexp(m[0], c[3], d));
			rd(8'h98, c | 8'h42);
			chk({8'h00, port_irq}, 9'h001);
			@(posedge clk);
			port_irq_enable <= 1'b0;
			repeat (2) @(posedge clk);
			chk({8'h00, port_irq}, 9'h000);
			port_irq_enable <= 1'b1;
			wr(8'h98, c | 8'h20);
			e = 8'($urandom);
			u_far.send(e, 1'b0);
			rd(8'h98, c | 8'h60);
			u_far.send(e, 1'b1);
			rd(8'h98, c | 8'h65);
			rd(8'h99, e);
			chk({8'h00, port_irq}, 9'h001);
			u_far.send(~e, 1'b1);
			rd(8'h99, e);
			wr(8'h98, c & 8'hef);
			u_far.send(~e, 1'b1);
			rd(8'h98, (c & 8'hef) | 8'h40);
		end
		// Far side cannot stall, so twenty quick writes must overrun the queue
		wr(8'h98, 8'h90);
		for (int i = 0; i < 20; i++) begin
			d = 8'($urandom);
			wr(8'h99, d);
			if (acc === 1'b1) begin
				q.push_back(fexp(1'b1, 1'b0, d));
			end
		end
		chk({8'h00, sfr_wr_ready}, 9'h000);
		// One frame in the shifter plus a full queue
		chk(9'(q.size()), 9'(ucdb_pkg::FIFO_DEPTH + 1));
		while (u_far.got.size() < q.size()) @(posedge clk);
		while (q.size() > 0) begin
			chk(u_far.got.pop_front(), q.pop_front());
		end
		// Dropped writes must never reach the line
		repeat (300) @(posedge clk);
		chk(9'(u_far.got.size()), 9'h000);
		chk({8'h00, sfr_wr_ready}, 9'h001);
		stop_test();
	end
endmodule
